// File: sdt_split_timer.sv
// split-mode dual 8-bit timer: APB register file, commands, flags, waveform pins
// assumes a zero-wait APB master and a debug halt level on the same clock
//
// Function
// RULE1 - clock select divides by 1..1024
// RULE2 - run bit enables the timer
// RULE3 - lane enable bits hand pins to waveform
// RULE4 - idle level bits set outputs while stopped
// RULE5 - split bit runs two 8-bit counters
// RULE6 - command field always reads zero
// RULE7 - commands: none, restart, hard reset
// RULE8 - target field selects both counters
// RULE9 - software writes command together with target
// RULE10 - clear port clears only bits written one
// RULE11 - set port sets only bits written one
// RULE12 - enable bits gate interrupt requests
// RULE13 - low counter match sets channel flag
// RULE14 - flags stay until written one
// RULE15 - high bottom sets high underflow flag
// RULE16 - low bottom sets low underflow flag
// RULE17 - counter write beats count and reload
// RULE18 - own top and compare per counter
// RULE19 - debug halt stops unless run bit set
// RULE20 - count down per tick, reload at zero
//
// Design decision made here: the APB interface to the registers.
`default_nettype none

module sdt_split_timer (
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        DEBUG_HALT_IN,
  output logic      [5:0]  WAVEFORM_PIN_OUT,
  output logic      [5:0]  WAVEFORM_PIN_OE_OUT,
  output logic             IRQ_REQ_OUT
);
  import sdt_pkg::*;

  // register state
  logic [7:0] prescale_and_run_reg;
  logic [7:0] lane_output_enable_reg;
  logic [7:0] idle_output_level_reg;
  logic [7:0] split_select_reg;
  logic [1:0] command_target_reg;
  logic [7:0] irq_enable_reg;
  logic [7:0] irq_flags_reg;
  logic [7:0] irq_flags_next;
  logic [7:0] debug_control_reg;
  logic [7:0] low_top_value_reg;
  logic [7:0] high_top_value_reg;
  logic [7:0] compare_reg [0:2*NUM_CHANNELS-1];
  logic [31:0] prdata_reg;
  logic        pslverr_reg;
  logic        irq_req_reg;
  logic [5:0]  pin_oe_reg;

  // bus decode
  logic [5:0] reg_index;
  logic       setup_phase;
  logic       access_phase;
  logic       addr_ok;
  logic       wr_en;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;
  logic [2:0] compare_sel;

  // timer control
  logic       run_enable;
  logic       split_operation;
  logic       counting;
  logic       tick;
  logic       cmd_write;
  logic [1:0] cmd_code;
  logic       target_both;
  logic       restart_cmd;
  logic       hard_reset_cmd;
  logic       clear_all;
  logic [7:0] low_counter_value;
  logic [7:0] high_counter_value;
  logic       low_underflow;
  logic       high_underflow;
  logic [NUM_CHANNELS-1:0] low_channel_match;
  logic [5:0] wave_level;
  logic [7:0] flag_set;
  logic [7:0] flag_clear;

  // which indices answer; the split layout only exists with the split bit set
  function automatic logic map_hit(input logic [5:0] idx, input logic split);
    logic common;
    logic split_only;
    common     = (idx == IDX_PRESCALE_AND_RUN) || (idx == IDX_SPLIT_SELECT) ||
                 (idx == IDX_DEBUG_CONTROL);
    split_only = (idx == IDX_LANE_OUTPUT_EN) || (idx == IDX_IDLE_OUTPUT_LVL) ||
                 (idx == IDX_COMMAND_CLEAR) || (idx == IDX_COMMAND_SET) ||
                 (idx == IDX_IRQ_ENABLE) || (idx == IDX_IRQ_FLAGS) ||
                 (idx == IDX_LOW_COUNT) || (idx == IDX_HIGH_COUNT) ||
                 (idx == IDX_LOW_TOP) || (idx == IDX_HIGH_TOP) ||
                 ((idx >= IDX_COMPARE_BASE) && (idx <= IDX_COMPARE_LAST));
    return common || (split && split_only); // see RULE5
  endfunction : map_hit

  // apb phases; registers live in byte lane 0 only
  assign reg_index    = PADDR_IN[7:2];
  assign setup_phase  = PSEL_IN && !PENABLE_IN;
  assign access_phase = PSEL_IN && PENABLE_IN;
  assign addr_ok      = (PADDR_IN[1:0] == 2'h0) && map_hit(reg_index, split_operation);
  assign wr_en        = access_phase && PWRITE_IN && PSTRB_IN[0] && addr_ok;
  assign wr_byte      = PWDATA_IN[7:0];
  assign compare_sel  = 3'(reg_index - IDX_COMPARE_BASE);

  // run conditions
  assign run_enable      = prescale_and_run_reg[RUN_BIT]; // see RULE2
  assign split_operation = split_select_reg[SPLIT_BIT]; // see RULE5
  assign counting        = run_enable && split_operation &&
                           !(DEBUG_HALT_IN && !debug_control_reg[RUN_HALTED_BIT]); // see RULE19

  // commands act only when written with target both, from either port
  assign cmd_write      = wr_en && ((reg_index == IDX_COMMAND_SET) ||
                                    (reg_index == IDX_COMMAND_CLEAR));
  assign cmd_code       = wr_byte[COMMAND_LSB +: 2];
  assign target_both    = (wr_byte[TARGET_LSB +: 2] == TARGET_BOTH); // see RULE8
  assign restart_cmd    = cmd_write && target_both && (cmd_code == CMD_RESTART); // see RULE7
  assign hard_reset_cmd = cmd_write && target_both && (cmd_code == CMD_HARD_RESET) &&
                          !run_enable; // see RULE7
  // hard reset returns every register except the APB read data and error to its reset value; it cannot fire while running
  assign clear_all      = RST_IN || hard_reset_cmd;

  sdt_prescaler #(
    .CNT_W (PRESCALE_CNT_W)
  ) u_prescaler (
    .clk_in    (CLK_IN),
    .rst_in    (clear_all),
    .run_in    (counting),
    .clear_in  (restart_cmd),
    .select_in (prescale_and_run_reg[PRESCALE_LSB +: PRESCALE_W]),
    .tick_out  (tick)
  );

  sdt_byte_counter #(
    .WIDTH (8)
  ) u_low_counter (
    .clk_in        (CLK_IN),
    .rst_in        (clear_all),
    .tick_in       (tick),
    .restart_in    (restart_cmd),
    .load_in       (wr_en && (reg_index == IDX_LOW_COUNT)), // see RULE17
    .load_value_in (wr_byte),
    .top_in        (low_top_value_reg), // see RULE18
    .count_out     (low_counter_value),
    .underflow_out (low_underflow)
  );

  sdt_byte_counter #(
    .WIDTH (8)
  ) u_high_counter (
    .clk_in        (CLK_IN),
    .rst_in        (clear_all),
    .tick_in       (tick),
    .restart_in    (restart_cmd),
    .load_in       (wr_en && (reg_index == IDX_HIGH_COUNT)), // see RULE17
    .load_value_in (wr_byte),
    .top_in        (high_top_value_reg), // see RULE18
    .count_out     (high_counter_value),
    .underflow_out (high_underflow)
  );

  // per-channel compare and waveform level; low channel k at compare_reg[2k], high at [2k+1]
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
      logic low_wave_reg;
      logic high_wave_reg;

      // match sampled on the counting tick so a parked counter does not refire the flag
      assign low_channel_match[ch] = tick &&
                                     (low_counter_value == compare_reg[2*ch]); // see RULE13

      // stopped: outputs follow the idle levels; running: high while count below compare
      always_ff @(posedge CLK_IN) begin
        if (clear_all) begin
          low_wave_reg  <= 1'b0;
          high_wave_reg <= 1'b0;
        end else if (!run_enable) begin
          low_wave_reg  <= idle_output_level_reg[LOW_LANE_LSB + ch]; // see RULE4
          high_wave_reg <= idle_output_level_reg[HIGH_LANE_LSB + ch]; // see RULE4
        end else if (tick) begin
          low_wave_reg  <= (low_counter_value < compare_reg[2*ch]); // see RULE18
          high_wave_reg <= (high_counter_value < compare_reg[2*ch+1]); // see RULE18
        end
      end

      assign wave_level[ch]                = low_wave_reg;
      assign wave_level[NUM_CHANNELS + ch] = high_wave_reg;
    end
  endgenerate

  // control registers written directly by software
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      prescale_and_run_reg   <= RST_BYTE;
      lane_output_enable_reg <= RST_BYTE;
      idle_output_level_reg  <= RST_BYTE;
      split_select_reg       <= RST_BYTE;
      irq_enable_reg         <= RST_BYTE;
      debug_control_reg      <= RST_BYTE;
    end else if (wr_en) begin
      unique case (reg_index)
        IDX_PRESCALE_AND_RUN: prescale_and_run_reg   <= wr_byte & PRESCALE_RUN_MASK;
        IDX_LANE_OUTPUT_EN:   lane_output_enable_reg <= wr_byte & LANE_MASK; // see RULE3
        IDX_IDLE_OUTPUT_LVL:  idle_output_level_reg  <= wr_byte & LANE_MASK; // see RULE4
        IDX_SPLIT_SELECT:     split_select_reg       <= {7'h00, wr_byte[SPLIT_BIT]};
        IDX_IRQ_ENABLE:       irq_enable_reg         <= wr_byte & IRQ_MASK; // see RULE12
        IDX_DEBUG_CONTROL:    debug_control_reg      <= {7'h00, wr_byte[RUN_HALTED_BIT]};
        default: begin
        end
      endcase
    end
  end

  // top values reset to all ones so a fresh counter runs the full range
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      low_top_value_reg  <= RST_TOP;
      high_top_value_reg <= RST_TOP;
    end else if (wr_en && (reg_index == IDX_LOW_TOP)) begin
      low_top_value_reg  <= wr_byte;
    end else if (wr_en && (reg_index == IDX_HIGH_TOP)) begin
      high_top_value_reg <= wr_byte;
    end
  end

  // compare values
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      for (int i = 0; i < 2*NUM_CHANNELS; i++) begin
        compare_reg[i] <= RST_BYTE;
      end
    end else if (wr_en && (reg_index >= IDX_COMPARE_BASE) &&
                 (reg_index <= IDX_COMPARE_LAST)) begin
      compare_reg[compare_sel] <= wr_byte;
    end
  end

  // target bits: set port ors ones in, clear port knocks ones out, command bits never stored
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      command_target_reg <= TARGET_NONE;
    end else if (wr_en && (reg_index == IDX_COMMAND_SET)) begin
      command_target_reg <= command_target_reg | wr_byte[TARGET_LSB +: 2]; // see RULE11
    end else if (wr_en && (reg_index == IDX_COMMAND_CLEAR)) begin
      command_target_reg <= command_target_reg & ~wr_byte[TARGET_LSB +: 2]; // see RULE10
    end
  end

  // flag sources and software clear
  always_comb begin
    flag_set = 8'h00;
    flag_set[IRQ_LOW_UNF_BIT]  = low_underflow; // see RULE16
    flag_set[IRQ_HIGH_UNF_BIT] = high_underflow; // see RULE15
    flag_set[IRQ_MATCH_LSB +: NUM_CHANNELS] = low_channel_match; // see RULE13
    flag_clear = (wr_en && (reg_index == IDX_IRQ_FLAGS)) ? (wr_byte & IRQ_MASK) : 8'h00;
    // a new event in the clearing cycle survives the clear
    irq_flags_next = (irq_flags_reg & ~flag_clear) | flag_set; // see RULE14
  end

  // sticky flags and the gated request
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      irq_flags_reg <= RST_BYTE;
      irq_req_reg   <= 1'b0;
    end else begin
      irq_flags_reg <= irq_flags_next; // see RULE14
      irq_req_reg   <= |(irq_flags_next & irq_enable_reg); // see RULE12
    end
  end

  // pin ownership only in split operation; otherwise the port register keeps the pin
  always_ff @(posedge CLK_IN) begin
    if (clear_all) begin
      pin_oe_reg <= 6'h00;
    end else begin
      pin_oe_reg <= split_operation ?
                    {lane_output_enable_reg[HIGH_LANE_LSB +: NUM_CHANNELS],
                     lane_output_enable_reg[LOW_LANE_LSB +: NUM_CHANNELS]} :
                    6'h00; // see RULE3
    end
  end

  // read mux; unmapped indices give zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (reg_index)
      IDX_PRESCALE_AND_RUN: rd_byte = prescale_and_run_reg;
      IDX_LANE_OUTPUT_EN:   rd_byte = lane_output_enable_reg;
      IDX_IDLE_OUTPUT_LVL:  rd_byte = idle_output_level_reg;
      IDX_SPLIT_SELECT:     rd_byte = split_select_reg;
      IDX_COMMAND_CLEAR,
      IDX_COMMAND_SET:      rd_byte = {6'h00, command_target_reg}; // see RULE6
      IDX_IRQ_ENABLE:       rd_byte = irq_enable_reg;
      IDX_IRQ_FLAGS:        rd_byte = irq_flags_reg;
      IDX_DEBUG_CONTROL:    rd_byte = debug_control_reg;
      IDX_LOW_COUNT:        rd_byte = low_counter_value;
      IDX_HIGH_COUNT:       rd_byte = high_counter_value;
      IDX_LOW_TOP:          rd_byte = low_top_value_reg;
      IDX_HIGH_TOP:         rd_byte = high_top_value_reg;
      default: begin
        if ((reg_index >= IDX_COMPARE_BASE) && (reg_index <= IDX_COMPARE_LAST)) begin
          rd_byte = compare_reg[compare_sel];
        end
      end
    endcase
  end

  // read data and error captured in the setup cycle, so the access phase needs no wait
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= (addr_ok && !PWRITE_IN) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr_reg <= !addr_ok;
    end
  end

  assign PRDATA_OUT          = prdata_reg;
  assign PREADY_OUT          = 1'b1;
  assign PSLVERR_OUT         = pslverr_reg;
  assign WAVEFORM_PIN_OUT    = wave_level;
  assign WAVEFORM_PIN_OE_OUT = pin_oe_reg;
  assign IRQ_REQ_OUT         = irq_req_reg;

endmodule : sdt_split_timer

`default_nettype wire

// File: sdt_pkg.sv
// constants shared by the split-mode dual 8-bit timer files
// assumes registers sit one per aligned 32-bit word, byte address = index * 4
`default_nettype none

package sdt_pkg;

  // register indices (byte address is four times the index)
  localparam logic [5:0] IDX_PRESCALE_AND_RUN = 6'h00;
  localparam logic [5:0] IDX_LANE_OUTPUT_EN   = 6'h01;
  localparam logic [5:0] IDX_IDLE_OUTPUT_LVL  = 6'h02;
  localparam logic [5:0] IDX_SPLIT_SELECT     = 6'h03;
  localparam logic [5:0] IDX_COMMAND_CLEAR    = 6'h04;
  localparam logic [5:0] IDX_COMMAND_SET      = 6'h05;
  localparam logic [5:0] IDX_IRQ_ENABLE       = 6'h0A;
  localparam logic [5:0] IDX_IRQ_FLAGS        = 6'h0B;
  localparam logic [5:0] IDX_DEBUG_CONTROL    = 6'h0E;
  localparam logic [5:0] IDX_LOW_COUNT        = 6'h20;
  localparam logic [5:0] IDX_HIGH_COUNT       = 6'h21;
  localparam logic [5:0] IDX_LOW_TOP          = 6'h26;
  localparam logic [5:0] IDX_HIGH_TOP         = 6'h27;
  localparam logic [5:0] IDX_COMPARE_BASE     = 6'h28;
  localparam logic [5:0] IDX_COMPARE_LAST     = 6'h2D;

  // field positions
  localparam int unsigned RUN_BIT          = 0;
  localparam int unsigned PRESCALE_LSB     = 1;
  localparam int unsigned PRESCALE_W       = 3;
  localparam int unsigned SPLIT_BIT        = 0;
  localparam int unsigned TARGET_LSB       = 0;
  localparam int unsigned COMMAND_LSB      = 2;
  localparam int unsigned LOW_LANE_LSB     = 0;
  localparam int unsigned HIGH_LANE_LSB    = 4;
  localparam int unsigned IRQ_LOW_UNF_BIT  = 0;
  localparam int unsigned IRQ_HIGH_UNF_BIT = 1;
  localparam int unsigned IRQ_MATCH_LSB    = 4;
  localparam int unsigned RUN_HALTED_BIT   = 0;
  localparam int unsigned NUM_CHANNELS     = 3;

  // writable bit masks
  localparam logic [7:0] PRESCALE_RUN_MASK = 8'h0F;
  localparam logic [7:0] LANE_MASK         = 8'h77;
  localparam logic [7:0] IRQ_MASK          = 8'h73;

  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [7:0] RST_TOP   = 8'hFF;
  localparam logic [7:0] RST_COUNT = 8'h00;

  // command and target codes
  localparam logic [1:0] CMD_NONE       = 2'h0;
  localparam logic [1:0] CMD_RESTART    = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET = 2'h3;
  localparam logic [1:0] TARGET_NONE    = 2'h0;
  localparam logic [1:0] TARGET_BOTH    = 2'h3;

  // prescaler counter width, enough for division by 1024
  localparam int unsigned PRESCALE_CNT_W = 10;

endpackage : sdt_pkg

`default_nettype wire

// File: sdt_prescaler.sv
// prescaler: turns the peripheral clock into a counting tick
// assumes run_in and clear_in come from logic on the same clock
`default_nettype none

module sdt_prescaler #(
  parameter int unsigned CNT_W = sdt_pkg::PRESCALE_CNT_W
) (
  input  wire logic                               clk_in,
  input  wire logic                               rst_in,
  input  wire logic                               run_in,
  input  wire logic                               clear_in,
  input  wire logic [sdt_pkg::PRESCALE_W-1:0]     select_in,
  output logic                                    tick_out
);
  import sdt_pkg::*;

  logic [CNT_W-1:0] div_cnt_reg;
  logic [CNT_W-1:0] div_mask;

  // code to low-bit mask: divide by 1,2,4,8,16,64,256,1024
  always_comb begin
    unique case (select_in)
      3'h0:    div_mask = CNT_W'(10'h000); // see RULE1
      3'h1:    div_mask = CNT_W'(10'h001);
      3'h2:    div_mask = CNT_W'(10'h003);
      3'h3:    div_mask = CNT_W'(10'h007);
      3'h4:    div_mask = CNT_W'(10'h00F);
      3'h5:    div_mask = CNT_W'(10'h03F);
      3'h6:    div_mask = CNT_W'(10'h0FF);
      default: div_mask = CNT_W'(10'h3FF);
    endcase
  end

  // free count while running; held at zero when stopped so the first tick is a full period
  always_ff @(posedge clk_in) begin
    if (rst_in || clear_in || !run_in) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + CNT_W'(1);
    end
  end

  assign tick_out = run_in && ((div_cnt_reg & div_mask) == div_mask); // see RULE1

endmodule : sdt_prescaler

`default_nettype wire

// File: sdt_byte_counter.sv
// one 8-bit down counter of the split timer, with reload from its top value
// assumes all inputs are on the same clock
`default_nettype none

module sdt_byte_counter #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             tick_in,
  input  wire logic             restart_in,
  input  wire logic             load_in,
  input  wire logic [WIDTH-1:0] load_value_in,
  input  wire logic [WIDTH-1:0] top_in,
  output logic      [WIDTH-1:0] count_out,
  output logic                  underflow_out
);
  import sdt_pkg::*;

  logic [WIDTH-1:0] count_reg;

  // a bus write wins over restart and counting
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count_reg <= WIDTH'(RST_COUNT);
    end else if (load_in) begin
      count_reg <= load_value_in; // see RULE17
    end else if (restart_in) begin
      count_reg <= top_in;
    end else if (tick_in) begin
      if (count_reg == '0) begin
        count_reg <= top_in; // see RULE20
      end else begin
        count_reg <= count_reg - WIDTH'(1); // see RULE20
      end
    end
  end

  assign count_out     = count_reg;
  // bottom event lost on purpose when a write overrides the same tick
  assign underflow_out = tick_in && !load_in && !restart_in && (count_reg == '0); // see RULE20

endmodule : sdt_byte_counter

`default_nettype wire

// File: sdt_split_timer_chk.sv
// checker for sdt_split_timer: port-level relations of the split timer
// assumes it sees only the top ports; shadows a few registers from APB writes
`default_nettype none

module sdt_split_timer_chk (
  input wire logic        CLK_IN,
  input wire logic        RST_IN,
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0]  PSTRB_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PREADY_OUT,
  input wire logic        PSLVERR_OUT,
  input wire logic        DEBUG_HALT_IN,
  input wire logic [5:0]  WAVEFORM_PIN_OUT,
  input wire logic [5:0]  WAVEFORM_PIN_OE_OUT,
  input wire logic        IRQ_REQ_OUT
);
  logic       wr;
  logic [1:0] quiet;
  logic       run_q;
  logic       split_q;
  logic [7:0] lane_q;
  logic [7:0] idle_q;
  logic [7:0] ien_q;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0] && PADDR_IN[1:0] == 2'h0;

  // shadow registers; a hard reset command while stopped clears them like reset
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || (wr && split_q && PADDR_IN[7:3] == 5'h02 && PWDATA_IN[3:0] == 4'hF &&
                   !run_q)) begin
      run_q   <= 1'b0;
      split_q <= 1'b0;
      lane_q  <= 8'h00;
      idle_q  <= 8'h00;
      ien_q   <= 8'h00;
    end else if (wr) begin
      case (PADDR_IN)
        8'h00: run_q <= PWDATA_IN[0];
        8'h0C: split_q <= PWDATA_IN[0];
        8'h04: if (split_q) lane_q <= PWDATA_IN[7:0] & 8'h77;
        8'h08: if (split_q) idle_q <= PWDATA_IN[7:0] & 8'h77;
        8'h28: if (split_q) ien_q <= PWDATA_IN[7:0] & 8'h73;
        default: ;
      endcase
    end
  end

  // cycles since the last write, so registered outputs have settled
  always_ff @(posedge CLK_IN) begin
    if (RST_IN || wr) quiet <= 2'h0;
    else if (quiet != 2'h3) quiet <= quiet + 2'h1;
  end

  a_oe_lane: assert property (quiet == 2'h3 |->
    WAVEFORM_PIN_OE_OUT == (split_q ? {lane_q[6:4], lane_q[2:0]} : 6'h00))
    else $error("pin enables differ from lane enables");
  a_idle_level: assert property (!run_q && quiet == 2'h3 |->
    WAVEFORM_PIN_OUT == {idle_q[6:4], idle_q[2:0]}) else $error("stopped pin not idle level");
  a_irq_gated: assert property (IRQ_REQ_OUT && quiet == 2'h3 |-> ien_q != 8'h00)
    else $error("request with all enables clear");
  a_irq_cause: assert property ($rose(IRQ_REQ_OUT) |->
    (run_q && split_q) || quiet != 2'h3) else $error("request rose while idle");
  a_flags_hold: assert property (IRQ_REQ_OUT && quiet[1] && !wr |=> IRQ_REQ_OUT)
    else $error("request dropped without a write");
  a_cmd_zero: assert property (PSEL_IN && PENABLE_IN && !PWRITE_IN &&
    PADDR_IN[7:3] == 5'h02 |-> PRDATA_OUT[3:2] == 2'h0) else $error("command field read nonzero");
  a_map_switch: assert property (PSEL_IN && PENABLE_IN && PADDR_IN == 8'h04
    |-> PSLVERR_OUT == !split_q) else $error("lane register mapping wrong");
  a_rdata_upper: assert property (PSEL_IN && PENABLE_IN && !PWRITE_IN
    |-> PRDATA_OUT[31:8] == 24'h00_0000) else $error("read data upper bits set");
  a_ready_high: assert property (PREADY_OUT) else $error("ready low");
  a_reset_quiet: assert property (@(posedge CLK_IN) disable iff (1'b0) RST_IN ##1 RST_IN
    |-> WAVEFORM_PIN_OE_OUT == 6'h00 && !IRQ_REQ_OUT) else $error("outputs active in reset");
endmodule : sdt_split_timer_chk

bind sdt_split_timer sdt_split_timer_chk u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PRDATA_OUT(PRDATA_OUT),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .DEBUG_HALT_IN(DEBUG_HALT_IN),
  .WAVEFORM_PIN_OUT(WAVEFORM_PIN_OUT), .WAVEFORM_PIN_OE_OUT(WAVEFORM_PIN_OE_OUT),
  .IRQ_REQ_OUT(IRQ_REQ_OUT));

`default_nettype wire

// File: sdt_split_timer_tb_top.sv
// testbench for sdt_split_timer: register map, commands, flags, prescaler
// assumes a zero-wait APB slave; the bench drives every port itself
`default_nettype none

module sdt_split_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a, rst, wd, rd; logic err;} sdt_row_t;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic        halt = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, e;
  logic [5:0]  pin, oe;
  logic [7:0]  v;
  int          num_errors = 0;
  int          n_tests = 0;
  int          dv [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
  // address, reset value, write value, read-back value, error expected
  sdt_row_t    rows [10] = '{'{8'h00, 8'h00, 8'hFE, 8'h0E, 1'b0},
    '{8'h04, 8'h00, 8'hFF, 8'h77, 1'b0},
    '{8'h08, 8'h00, 8'hFF, 8'h77, 1'b0}, '{8'h0C, 8'h01, 8'hFF, 8'h01, 1'b0},
    '{8'h28, 8'h00, 8'hFF, 8'h73, 1'b0}, '{8'h9C, 8'hFF, 8'h5A, 8'h5A, 1'b0},
    '{8'hA0, 8'h00, 8'h01, 8'h01, 1'b0}, '{8'hA8, 8'h00, 8'h02, 8'h02, 1'b0},
    '{8'hB0, 8'h00, 8'h05, 8'h05, 1'b0}, '{8'h18, 8'h00, 8'hFF, 8'h00, 1'b1}};

  always #5 clk = ~clk;

  sdt_split_timer u_sdt_split_timer (.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .DEBUG_HALT_IN(halt),
    .WAVEFORM_PIN_OUT(pin), .WAVEFORM_PIN_OE_OUT(oe), .IRQ_REQ_OUT(irq));

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one APB transfer; request held until ready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end
    v = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : xfer

  task automatic rdc(input logic [7:0] a, input logic [7:0] x);
    xfer(a, 1'b0, 8'h00);
    chk(v, x);
  endtask : rdc

  // low counter from 0xFF, run w cycles plus transfer overhead, stop, read back
  task automatic span(input logic [2:0] s, input int w);
    xfer(8'h80, 1'b1, 8'hFF);
    xfer(8'h00, 1'b1, {4'h0, s, 1'b1});
    repeat (w) @(posedge clk);
    xfer(8'h00, 1'b1, {4'h0, s, 1'b0});
    xfer(8'h80, 1'b0, 8'h00);
  endtask : span

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h0C, 8'h00);
    chk(oe, 6'h00);
    xfer(8'h04, 1'b0, 8'h00);
    chk(e, 1'b1);
    xfer(8'h0C, 1'b1, 8'h01);
    // register table: reset value, masked write, read back
    foreach (rows[i]) begin
      xfer(rows[i].a, 1'b0, 8'h00);
      chk({e, v}, {rows[i].err, rows[i].rst});
      xfer(rows[i].a, 1'b1, rows[i].wd);
      xfer(rows[i].a, 1'b0, 8'h00);
      chk({e, v}, {rows[i].err, rows[i].rd});
    end
    repeat (2) @(posedge clk);
    chk({pin, oe}, 12'hFFF);
    // commands: the command field never reads back, target bits set and clear
    xfer(8'h14, 1'b1, 8'h07);
    rdc(8'h14, 8'h03);
    xfer(8'h10, 1'b1, 8'h01);
    rdc(8'h10, 8'h02);
    xfer(8'h14, 1'b1, 8'h01);
    rdc(8'h14, 8'h03);
    xfer(8'h80, 1'b1, 8'h10);
    xfer(8'h14, 1'b1, 8'h0B);
    rdc(8'h80, 8'hFF);
    // spans of four and a half ticks (four at divide by 1) give exactly four decrements
    for (int i = 0; i < 8; i++) begin
      span(i[2:0], 4 * dv[i] + dv[i] / 2 - 3);
      chk(v, 8'hFB);
    end
    repeat (20) @(posedge clk);
    rdc(8'h80, 8'hFB);
    halt <= 1'b1;
    span(3'h0, 10);
    chk(v, 8'hFF);
    xfer(8'h38, 1'b1, 8'h01);
    span(3'h0, 1);
    chk(v, 8'hFB);
    halt <= 1'b0;
    // flags: underflow of both halves and low match of channels 0 and 1
    xfer(8'h2C, 1'b1, 8'hFF);
    xfer(8'h98, 1'b1, 8'h02);
    xfer(8'h80, 1'b1, 8'h02);
    xfer(8'h84, 1'b1, 8'h01);
    xfer(8'h00, 1'b1, 8'h01);
    repeat (10) @(posedge clk);
    xfer(8'h00, 1'b1, 8'h00);
    rdc(8'h2C, 8'h33);
    chk(irq, 1'b1);
    xfer(8'h2C, 1'b1, 8'h01);
    rdc(8'h2C, 8'h32);
    xfer(8'h28, 1'b1, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    // hard reset: wrong target and running both ignored
    xfer(8'h14, 1'b1, 8'h0D);
    rdc(8'h0C, 8'h01);
    xfer(8'h00, 1'b1, 8'h01);
    // a count write while ticking every cycle lands, then one tick before the capture
    xfer(8'h80, 1'b1, 8'h40);
    rdc(8'h80, 8'h3F);
    xfer(8'h14, 1'b1, 8'h0F);
    rdc(8'h0C, 8'h01);
    xfer(8'h00, 1'b1, 8'h00);
    xfer(8'h14, 1'b1, 8'h0F);
    rdc(8'h0C, 8'h00);
    stop_test();
  end
endmodule : sdt_split_timer_tb_top

`default_nettype wire
